// file: verilog/pkz_packetizer.sv
// Serial port packetizer: buffers received characters and releases them
// as packets on length, delimiter, idle timeout or full buffer.
// Assumes rx and packet streams on hclk; registers over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module pkz_packetizer #(
  parameter int unsigned CYC_PER_MS = pkz_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial receive stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Packet stream
  output logic pkt_valid,
  output logic [7:0] pkt_data,
  output logic pkt_last,
  input wire logic pkt_ready
);
  pkz_pkg::pkz_cfg_type cfg_q;
  pkz_pkg::pkz_state_type state_q;
  pkz_pkg::pkz_char_type out_q;
  logic [7:0] buf_mem [pkz_pkg::BUF_DEPTH];
  logic [10:0] count_q;
  logic [10:0] plen_q;
  logic [10:0] rd_q;
  logic [1:0] pend_q;
  logic prev_d1_q;
  logic out_valid_q;
  logic wr_q;
  logic rd_sel_q;
  logic [3:0] addr_q;
  logic accept;
  logic [10:0] cnt_n;
  logic delim_hit;
  logic [10:0] dcount;
  logic trig_len;
  logic trig_full;
  logic trig_delim;
  logic trig_pend;
  logic trig_idle;
  logic pack;
  logic idle_exp;
  logic out_take;
  logic [10:0] plen_n;

  // Bus slave: zero wait states, always OKAY
  logic addr_ok;
  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_sel_q <= 1'b0;
      addr_q <= 4'h0;
    end else begin
      wr_q <= addr_ok && hwrite;
      rd_sel_q <= addr_ok && !hwrite;
      if (addr_ok) begin
        addr_q <= {haddr[3:2], 2'h0};
      end
    end
  end

  // Upper address bits ignored; higher words alias the four registers
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_sel_q) begin
      case (addr_q)
        pkz_pkg::OFS_LEN: hrdata[10:0] = cfg_q.pack_len;
        pkz_pkg::OFS_DELIM: begin
          hrdata[pkz_pkg::F_D1 +: 8] = cfg_q.d1;
          hrdata[pkz_pkg::F_D2 +: 8] = cfg_q.d2;
          hrdata[pkz_pkg::F_EN1] = cfg_q.en1;
          hrdata[pkz_pkg::F_EN2] = cfg_q.en2;
          hrdata[pkz_pkg::F_PROC +: 2] = cfg_q.proc;
        end
        pkz_pkg::OFS_IDLE: hrdata[15:0] = cfg_q.idle_ms;
        pkz_pkg::OFS_STATUS: begin
          hrdata[10:0] = count_q;
          hrdata[pkz_pkg::F_DRAIN] = (state_q == pkz_pkg::ST_DRAIN);
          hrdata[pkz_pkg::F_PEND +: 2] = pend_q;
        end
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q.pack_len <= pkz_pkg::RST_LEN;
      cfg_q.d1 <= pkz_pkg::RST_DELIM;
      cfg_q.d2 <= pkz_pkg::RST_DELIM;
      cfg_q.en1 <= 1'b0;
      cfg_q.en2 <= 1'b0;
      cfg_q.proc <= pkz_pkg::PROC_NONE;
      cfg_q.idle_ms <= pkz_pkg::RST_IDLE;
    end else if (wr_q) begin
      case (addr_q)
        pkz_pkg::OFS_LEN: cfg_q.pack_len <= hwdata[10:0];
        pkz_pkg::OFS_DELIM: begin
          cfg_q.d1 <= hwdata[pkz_pkg::F_D1 +: 8];
          cfg_q.d2 <= hwdata[pkz_pkg::F_D2 +: 8];
          cfg_q.en1 <= hwdata[pkz_pkg::F_EN1];
          cfg_q.en2 <= hwdata[pkz_pkg::F_EN2];
          cfg_q.proc <= pkz_pkg::pkz_proc_type'(hwdata[pkz_pkg::F_PROC +: 2]);
        end
        pkz_pkg::OFS_IDLE: cfg_q.idle_ms <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Trigger detection on the accepted character, or on idle expiry with none accepted
  assign rx_ready = (state_q == pkz_pkg::ST_COLLECT) && (count_q != pkz_pkg::BUF_FULL);
  assign accept = rx_valid && rx_ready;
  assign cnt_n = count_q + 11'h001;
  // Second delimiter alone does nothing
  assign delim_hit = accept && cfg_q.en1 &&
    (cfg_q.en2 ? (prev_d1_q && rx_data == cfg_q.d2) : (rx_data == cfg_q.d1));
  assign dcount = cfg_q.en2 ? 11'h002 : 11'h001;
  assign trig_len = accept && (cfg_q.pack_len != 11'h000) && (cnt_n >= cfg_q.pack_len);
  assign trig_full = accept && (cnt_n == pkz_pkg::BUF_FULL);
  assign trig_delim = delim_hit &&
    (cfg_q.proc == pkz_pkg::PROC_NONE || cfg_q.proc == pkz_pkg::PROC_STRIP);
  assign trig_pend = accept && (pend_q == 2'h1);
  assign trig_idle = idle_exp && !accept && (count_q != 11'h000) &&
    (state_q == pkz_pkg::ST_COLLECT);
  assign pack = trig_len || trig_full || trig_delim || trig_pend || trig_idle;

  // Strip shortens the packet; the characters stay in the buffer unread
  always_comb begin
    plen_n = accept ? cnt_n : count_q;
    if (delim_hit && cfg_q.proc == pkz_pkg::PROC_STRIP) begin
      plen_n = cnt_n - dcount;
    end
  end

  pkz_idle_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_idle (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(accept || pack),
    .run((state_q == pkz_pkg::ST_COLLECT) && (count_q != 11'h000)),
    .limit_ms(cfg_q.idle_ms),
    .expired(idle_exp)
  );

  always_ff @(posedge hclk) begin
    if (accept) begin
      buf_mem[count_q[9:0]] <= rx_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= 11'h000;
    end else if (pack) begin
      count_q <= 11'h000;
    end else if (accept) begin
      count_q <= cnt_n;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_d1_q <= 1'b0;
    end else if (pack) begin
      prev_d1_q <= 1'b0;
    end else if (accept) begin
      prev_d1_q <= (rx_data == cfg_q.d1);
    end
  end

  // Characters still owed after a plus-one or plus-two delimiter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 2'h0;
    end else if (pack) begin
      pend_q <= 2'h0;
    end else if (delim_hit && pend_q == 2'h0 && cfg_q.proc == pkz_pkg::PROC_PLUS1) begin
      pend_q <= 2'h1;
    end else if (delim_hit && pend_q == 2'h0 && cfg_q.proc == pkz_pkg::PROC_PLUS2) begin
      pend_q <= 2'h2;
    end else if (accept && pend_q != 2'h0) begin
      pend_q <= pend_q - 2'h1;
    end
  end

  // Drain: one character per accepted beat from a registered stage
  assign out_take = !out_valid_q || pkt_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= pkz_pkg::ST_COLLECT;
      plen_q <= 11'h000;
      rd_q <= 11'h000;
    end else begin
      case (state_q)
        pkz_pkg::ST_COLLECT: begin
          if (pack) begin
            state_q <= pkz_pkg::ST_DRAIN;
            plen_q <= plen_n;
            rd_q <= 11'h000;
          end
        end
        pkz_pkg::ST_DRAIN: begin
          if (out_take && rd_q != plen_q) begin
            rd_q <= rd_q + 11'h001;
          end else if (out_take) begin
            state_q <= pkz_pkg::ST_COLLECT;
          end
        end
        default: state_q <= pkz_pkg::ST_COLLECT;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid_q <= 1'b0;
      out_q <= '0;
    end else if (out_take) begin
      out_valid_q <= (state_q == pkz_pkg::ST_DRAIN) && (rd_q != plen_q);
      out_q.data <= buf_mem[rd_q[9:0]];
      out_q.last <= (rd_q + 11'h001 == plen_q);
    end
  end

  assign pkt_valid = out_valid_q;
  assign pkt_data = out_q.data;
  assign pkt_last = out_q.last;

  property p_len;
    @(posedge hclk) disable iff (!hresetn)
    accept && cfg_q.pack_len != 11'h000 && cnt_n == cfg_q.pack_len
      |=> state_q == pkz_pkg::ST_DRAIN && count_q == 11'h000;
  endproperty
  a_len: assert property (p_len) else $error("length threshold did not pack");

  property p_nolen;
    @(posedge hclk) disable iff (!hresetn)
    accept && cfg_q.pack_len == 11'h000 && !delim_hit && pend_q == 2'h0 &&
      cnt_n != pkz_pkg::BUF_FULL |=> state_q == pkz_pkg::ST_COLLECT;
  endproperty
  a_nolen: assert property (p_nolen) else $error("packed with no trigger");

  property p_full;
    @(posedge hclk) disable iff (!hresetn)
    accept && count_q == 11'h3ff |=> state_q == pkz_pkg::ST_DRAIN ##0 plen_q >= 11'h3fe;
  endproperty
  a_full: assert property (p_full) else $error("full buffer not packed");

  property p_pair;
    @(posedge hclk) disable iff (!hresetn)
    delim_hit && cfg_q.en2 |-> prev_d1_q && count_q != 11'h000;
  endproperty
  a_pair: assert property (p_pair) else $error("pair delimiter without first");

  property p_off;
    @(posedge hclk) disable iff (!hresetn)
    accept && !cfg_q.en1 && pend_q == 2'h0 |=> pend_q == 2'h0;
  endproperty
  a_off: assert property (p_off) else $error("delimiter seen while disabled");

  property p_none;
    @(posedge hclk) disable iff (!hresetn)
    delim_hit && cfg_q.proc == pkz_pkg::PROC_NONE && state_q == pkz_pkg::ST_COLLECT
      |=> state_q == pkz_pkg::ST_DRAIN && plen_q == $past(cnt_n);
  endproperty
  a_none: assert property (p_none) else $error("default process length wrong");

  property p_plus1;
    @(posedge hclk) disable iff (!hresetn)
    accept && pend_q == 2'h1 && cfg_q.proc == pkz_pkg::PROC_PLUS1
      |=> state_q == pkz_pkg::ST_DRAIN && count_q == 11'h000;
  endproperty
  a_plus1: assert property (p_plus1) else $error("plus one did not pack");

  property p_plus2;
    @(posedge hclk) disable iff (!hresetn)
    delim_hit && cfg_q.proc == pkz_pkg::PROC_PLUS2 && !pack && pend_q == 2'h0
      |=> pend_q == 2'h2 && state_q == pkz_pkg::ST_COLLECT;
  endproperty
  a_plus2: assert property (p_plus2) else $error("plus two not armed");

  property p_strip;
    @(posedge hclk) disable iff (!hresetn)
    delim_hit && cfg_q.proc == pkz_pkg::PROC_STRIP
      |=> plen_q == $past(cnt_n) - $past(dcount);
  endproperty
  a_strip: assert property (p_strip) else $error("strip length wrong");

  property p_idle;
    @(posedge hclk) disable iff (!hresetn)
    trig_idle |-> cfg_q.idle_ms != 16'h0000 ##1 state_q == pkz_pkg::ST_DRAIN;
  endproperty
  a_idle: assert property (p_idle) else $error("idle pack wrong");

  property p_one;
    @(posedge hclk) disable iff (!hresetn)
    pack |=> count_q == 11'h000 && pend_q == 2'h0 && !pack;
  endproperty
  a_one: assert property (p_one) else $error("trigger not single packet");
endmodule
`default_nettype wire

// file: verilog/pkz_pkg.sv
// Constants, register map and carrier types of the serial packetizer.
// Assumes a 125 MHz system clock and one AHB-Lite slave port.
package pkz_pkg;
  // Buffer
  localparam int unsigned BUF_DEPTH = 1024;
  localparam int unsigned CNT_W = 11;
  localparam logic [10:0] BUF_FULL = 11'h400;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned IDLE_UNIT_NS = 1000000;
  localparam int unsigned CYCLES_PER_MS = IDLE_UNIT_NS / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [3:0] OFS_LEN = 4'h0;
  localparam logic [3:0] OFS_DELIM = 4'h4;
  localparam logic [3:0] OFS_IDLE = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // Field positions
  localparam int unsigned F_D1 = 0;
  localparam int unsigned F_D2 = 8;
  localparam int unsigned F_EN1 = 16;
  localparam int unsigned F_EN2 = 17;
  localparam int unsigned F_PROC = 18;
  localparam int unsigned F_DRAIN = 16;
  localparam int unsigned F_PEND = 17;
  // Reset values
  localparam logic [10:0] RST_LEN = 11'h000;
  localparam logic [7:0] RST_DELIM = 8'h00;
  localparam logic [15:0] RST_IDLE = 16'h0000;

  typedef enum logic [1:0] {
    PROC_NONE = 2'h0,
    PROC_PLUS1 = 2'h1,
    PROC_PLUS2 = 2'h2,
    PROC_STRIP = 2'h3
  } pkz_proc_type;

  typedef enum {ST_COLLECT, ST_DRAIN} pkz_state_type;

  typedef struct packed {
    logic [10:0] pack_len;
    logic [7:0] d1;
    logic [7:0] d2;
    logic en1;
    logic en2;
    pkz_proc_type proc;
    logic [15:0] idle_ms;
  } pkz_cfg_type;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } pkz_char_type;
endpackage

// file: verilog/pkz_idle_timer.sv
// Idle interval timer in whole milliseconds for the packetizer.
// Assumes restart pulses on every accepted character and on each pack.
`timescale 1ns/1ps
`default_nettype none
module pkz_idle_timer #(
  parameter int unsigned CYC_PER_MS = pkz_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic restart,
  input wire logic run,
  input wire logic [15:0] limit_ms,
  // Result
  output logic expired
);
  localparam int unsigned PRE_W = $clog2(CYC_PER_MS + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);

  logic [PRE_W-1:0] pre_q;
  logic [15:0] ms_q;
  logic at_limit;

  assign at_limit = (ms_q == limit_ms);
  // Zero limit never expires
  assign expired = run && (limit_ms != 16'h0000) && at_limit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= '0;
    end else if (restart || !run || pre_q == PRE_LAST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  // Saturates at the limit so a late restart still sees expiry once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_q <= 16'h0000;
    end else if (restart || !run) begin
      ms_q <= 16'h0000;
    end else if (pre_q == PRE_LAST && !at_limit) begin
      ms_q <= ms_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: verif/pkz_far_end.sv
// Far side of the packetizer: serial source and packet sink.
// Assumes the bench fills tx_q and reads got_q by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module pkz_far_end (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial source
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Packet sink
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_last,
  input wire logic sink_go,
  output logic pkt_ready
);
  logic [7:0] tx_q[$];
  logic [8:0] got_q[$];
  // No connection close is modelled, so buffered data always drains
  assign pkt_ready = sink_go;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  always @(posedge hclk) begin
    if (pkt_valid && pkt_ready) begin
      got_q.push_back({pkt_last, pkt_data});
    end
    if (!hresetn) begin
      rx_valid <= 1'b0;
    end else if (rx_valid && !rx_ready) begin
      rx_valid <= 1'b1;
    end else if (tx_q.size() > 0) begin
      // Delimiters reach the port only as queued stream bytes
      rx_valid <= 1'b1;
      rx_data <= tx_q.pop_front();
    end else begin
      // Idle line toggles so no stale byte looks valid
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  end
endmodule
`default_nettype wire

// file: verif/serial_data_packetizer_tb.sv
// Self-checking bench for the packetizer against a queue model.
// Assumes one AHB-Lite slave; hready is fed back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module serial_data_packetizer_tb;
  localparam int unsigned CPM = 10;
  logic hclk, hresetn, hsel, hwrite, slow, sink_go;
  logic [31:0] haddr, hwdata, hrdata, rng;
  logic [1:0] htrans;
  logic hreadyout, hresp, rx_valid, rx_ready, pkt_valid, pkt_last, pkt_ready;
  logic [7:0] rx_data, pkt_data;
  int miscompares, checked, n;
  int m_len, m_d1, m_d2, m_en1, m_en2, m_proc, m_owe, m_prev;
  int m_buf[$];
  logic [8:0] exp_q[$];

  pkz_packetizer #(.CYC_PER_MS(CPM)) pkz_packetizer_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
  pkz_far_end pkz_far_end_inst (.hclk(hclk), .hresetn(hresetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
    .pkt_last(pkt_last), .sink_go(sink_go), .pkt_ready(pkt_ready));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(logic [31:0] a, logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk("register", e, d);
  endtask

  // Model emits the buffer, minus stripped delimiters, as one packet
  task automatic m_emit(int strip);
    int k;
    k = m_buf.size() - strip;
    for (int i = 0; i < k; i++) exp_q.push_back({i == k - 1, m_buf[i][7:0]});
    m_buf = {};
    m_owe = 0;
    m_prev = 0;
  endtask

  task automatic send(int c);
    int det, trig, strip;
    det = m_en1 && (m_en2 ? (m_prev && c == m_d2) : c == m_d1);
    m_prev = (c == m_d1);
    trig = 0;
    strip = 0;
    m_buf.push_back(c);
    if (m_owe > 0) begin
      m_owe--;
      trig = (m_owe == 0);
    end else if (det) begin
      if (m_proc == 1 || m_proc == 2) m_owe = m_proc;
      else trig = 1;
      if (m_proc == 3) strip = m_en2 ? 2 : 1;
    end
    if ((m_len > 0 && m_buf.size() >= m_len) || m_buf.size() == 1024) trig = 1;
    if (trig) m_emit(strip);
    pkz_far_end_inst.tx_q.push_back(c[7:0]);
  endtask

  task automatic send_s(string s);
    foreach (s[i]) send(s[i]);
  endtask

  task automatic cfg(int len, int d1, int d2, int e1, int e2, int p, int idle);
    logic [31:0] d;
    {m_len, m_d1, m_d2, m_en1, m_en2, m_proc} = {len, d1, d2, e1, e2, p};
    bus(1'b1, 32'(pkz_pkg::OFS_LEN), 32'(len), d);
    d = 32'(d1) | (32'(d2) << pkz_pkg::F_D2) | (32'(e1) << pkz_pkg::F_EN1);
    d = d | (32'(e2) << pkz_pkg::F_EN2) | (32'(p) << pkz_pkg::F_PROC);
    bus(1'b1, 32'(pkz_pkg::OFS_DELIM), d, d);
    bus(1'b1, 32'(pkz_pkg::OFS_IDLE), 32'(idle), d);
  endtask

  // Idle means no byte queued, none offered and no packet in flight;
  // the quiet span outlasts a short idle interval so an idle pack is not missed
  task automatic settle();
    int q;
    q = 0;
    while (q < 4 * CPM) begin
      @(posedge hclk);
      if (pkz_far_end_inst.tx_q.size() == 0 && rx_valid === 1'b0 && pkt_valid === 1'b0
          && rx_ready === 1'b1) q++;
      else q = 0;
    end
  endtask

  task automatic cmp_pkts();
    settle();
    chk("packet bytes", exp_q.size(), pkz_far_end_inst.got_q.size());
    foreach (exp_q[i]) begin
      if (i < pkz_far_end_inst.got_q.size()) chk("packet byte", exp_q[i],
        pkz_far_end_inst.got_q[i]);
    end
    exp_q = {};
    pkz_far_end_inst.got_q = {};
  endtask

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk) sink_go <= slow ? ((xs() & 32'h0000_0001) != 32'h0000_0000) : 1'b1;

  initial begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    wrap_up();
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, slow, sink_go} = '0;
    rng = 32'h0000039c;
    {miscompares, checked, m_owe, m_prev} = '0;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(32'(pkz_pkg::OFS_LEN), 32'h0);
    rd_chk(32'(pkz_pkg::OFS_DELIM), 32'h0);
    rd_chk(32'(pkz_pkg::OFS_IDLE), 32'h0);
    rd_chk(32'h00000010, 32'h0);
    slow <= 1'b1;
    cfg(5, 0, 0, 0, 0, 0, 0);
    rd_chk(32'(pkz_pkg::OFS_LEN), 32'h5);
    repeat (12) send(int'(xs() & 32'h0000_00ff));
    cmp_pkts();
    rd_chk(32'(pkz_pkg::OFS_STATUS), 32'h2);
    cfg(3, "\r", 0, 1, 0, 0, 0);
    send_s("\rab\r");
    cmp_pkts();
    slow <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      cfg(0, ",", 0, 1, 0, p, 0);
      send_s("ab,cd,,e,fgh,zz");
      cmp_pkts();
    end
    cfg(0, ",", 0, 0, 0, 2, 0);
    send_s(",x,");
    cmp_pkts();
    cfg(0, "\r", "\n", 1, 1, 0, 0);
    send_s("a\rb\nc\r\n");
    cmp_pkts();
    cfg(0, "\r", "\n", 1, 1, 3, 0);
    send_s("q\r\n\r\n");
    cmp_pkts();
    slow <= 1'b1;
    cfg(0, 0, 0, 0, 0, 0, 0);
    repeat (1030) send(int'(xs() & 32'h0000_00ff));
    cmp_pkts();
    repeat (200) @(posedge hclk);
    chk("idle off", 0, pkz_far_end_inst.got_q.size());
    cfg(0, 0, 0, 0, 0, 0, 2);
    m_emit(0);
    cmp_pkts();
    send_s("xyz");
    n = 0;
    while (pkz_far_end_inst.tx_q.size() > 0) @(posedge hclk);
    while (pkt_valid !== 1'b1 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    chk("idle gap", 1, n >= CPM && n <= 3 * CPM);
    m_emit(0);
    cmp_pkts();
    wrap_up();
  end
endmodule
`default_nettype wire
